// ==== rtl/scm_blinker.sv ====
/*
 Error indicator blinker.
 Assumes enable comes from logic on the same clock.
*/
module scm_blinker
	import scm_pkg::*;
#(
	parameter int HALF_PERIOD = SCM_BLINK_CYC
)
(
	// Clocking
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Control
	input wire logic blinkEn,
	output logic led
);
	typedef struct packed {
		logic [31:0] cnt;
		logic led;
	} scm_blink_s;
	scm_blink_s st_r;
	scm_blink_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (!blinkEn)
		begin
			st_nxt = '0;
		end
		else if (st_r.cnt >= 32'(HALF_PERIOD - 1))
		begin
			st_nxt.cnt = '0;
			st_nxt.led = !st_r.led;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	assign led = st_r.led;
endmodule : scm_blinker

// ==== rtl/scm_manager.sv ====
/*
 Safety configuration memory manager: start-up decision, copy and erase
 sequencing between device store and removable chip.
 Assumes the storage engine answers each request with a done pulse, and
 that switch and chip-present pins are asynchronous.
*/
module scm_manager
	import scm_pkg::*;
#(
	parameter int BLINK_HALF = SCM_BLINK_CYC
)
(
	// Clocking
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Pins
	input wire logic [9:0] switchSetting,
	input wire logic chipPresent,
	// Store status and tool events
	input wire scm_status_s status,
	input wire scm_tool_s tool,
	input wire logic checkOk,
	input wire logic xferDone,
	// Store requests
	output scm_req_s req,
	output logic checkStart,
	output logic resetFunc,
	// Indication
	output logic running,
	output logic [9:0] diagCode,
	output logic errLed
);
	typedef enum logic [2:0] {
		S_SAMPLE, S_SETTLE, S_DECIDE, S_XFER,
		S_RUN, S_CHECK, S_HALT, S_ERASE
	} scm_state_e;

	typedef struct packed {
		scm_state_e state;
		logic [9:0] swSync1;
		logic [9:0] swSync2;
		logic presSync1;
		logic presSync2;
		logic plugSinceStart;
		logic current;
		logic erasing;
		logic running;
		logic resetFunc;
		logic checkStart;
		logic [9:0] diag;
		scm_req_s req;
		logic afterXfer;
	} scm_core_s;

	scm_core_s st_r;
	scm_core_s st_nxt;
	logic blinkLed;
	logic chipIn;

	function automatic logic in9xx(input logic [9:0] sw);
		in9xx = (sw >= SCM_SW_9XX_LO) && (sw <= SCM_SW_9XX_HI);
	endfunction : in9xx

	function automatic scm_req_s mkReq(input scm_xfer_e k);
		mkReq.start = 1'b1;
		mkReq.kind = k;
		mkReq.section = SCM_SEC_SAFETY;
	endfunction : mkReq

	assign chipIn = st_r.presSync2;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.swSync1 = switchSetting;
		st_nxt.swSync2 = st_r.swSync1;
		st_nxt.presSync1 = chipPresent;
		st_nxt.presSync2 = st_r.presSync1;
		st_nxt.req.start = 1'b0;
		st_nxt.checkStart = 1'b0;
		if (!chipIn)
			st_nxt.plugSinceStart = 1'b0;
		unique case (st_r.state)
			// Second sync stage holds the pins only two edges after reset
			S_SAMPLE:
				st_nxt.state = S_SETTLE;
			S_SETTLE:
				st_nxt.state = S_DECIDE;
			S_DECIDE:
			begin
				st_nxt.plugSinceStart = chipIn;
				if (st_r.swSync2 == SCM_SW_RESET)
				begin
					st_nxt.resetFunc = 1'b1;
					st_nxt.state = S_HALT;
				end
				else if (st_r.swSync2 == SCM_SW_ERASE && chipIn)
				begin
					st_nxt.req = mkReq(XF_ERASE);
					st_nxt.erasing = 1'b1;
					st_nxt.state = S_ERASE;
				end
				else if (!status.devValid && !(chipIn && status.chipValid))
				begin
					st_nxt.diag = SCM_DIAG_NO_CONFIG;
					st_nxt.state = S_HALT;
				end
				else if (status.devValid && !chipIn)
				begin
					st_nxt.diag = SCM_DIAG_NO_CHIP;
					st_nxt.state = S_HALT;
				end
				else if (!status.devValid && !in9xx(st_r.swSync2))
				begin
					st_nxt.req = mkReq(XF_TO_DEV);
					st_nxt.running = 1'b1;
					st_nxt.state = S_XFER;
				end
				else if (!status.devValid)
				begin
					st_nxt.diag = SCM_DIAG_NO_CONFIG;
					st_nxt.state = S_HALT;
				end
				else if (!status.chipValid)
				begin
					st_nxt.req = mkReq(XF_TO_CHIP);
					st_nxt.running = 1'b1;
					st_nxt.state = S_XFER;
				end
				else
				begin
					st_nxt.running = 1'b1;
					st_nxt.current = status.copiesEqual;
					if (!status.copiesEqual)
						st_nxt.diag = SCM_DIAG_MISMATCH;
					st_nxt.state = S_RUN;
				end
			end
			S_XFER:
				if (xferDone)
				begin
					st_nxt.current = 1'b1;
					st_nxt.state = S_RUN;
				end
			S_ERASE:
				if (xferDone)
				begin
					st_nxt.erasing = 1'b0;
					st_nxt.current = 1'b0;
					st_nxt.state = st_r.running ? S_RUN : S_HALT;
				end
			S_CHECK:
				if (checkOk)
				begin
					st_nxt.req = mkReq(XF_TO_DEV);
					st_nxt.state = S_XFER;
				end
			S_RUN:
			begin
				if (!chipIn)
					st_nxt.diag = SCM_DIAG_NO_CHIP;
				if (tool.deleteCmd && chipIn)
				begin
					st_nxt.req = mkReq(XF_ERASE);
					st_nxt.erasing = 1'b1;
					st_nxt.state = S_ERASE;
				end
				else if (tool.downloadDone && chipIn &&
					st_r.plugSinceStart && st_r.current)
				begin
					st_nxt.req = mkReq(XF_TO_CHIP);
					st_nxt.state = S_XFER;
				end
				else if (tool.configChanged && chipIn &&
					status.chipValid && !status.copiesEqual)
				begin
					st_nxt.checkStart = 1'b1;
					st_nxt.state = S_CHECK;
				end
			end
			S_HALT:
				st_nxt.state = S_HALT;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	// Blink follows the erase flag only, so it stops one cycle after the erase flag clears
	scm_blinker #(.HALF_PERIOD(BLINK_HALF)) u_blink (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.blinkEn(st_r.erasing),
		.led(blinkLed)
	);

	assign req = st_r.req;
	assign checkStart = st_r.checkStart;
	assign resetFunc = st_r.resetFunc;
	assign running = st_r.running;
	assign diagCode = st_r.diag;
	assign errLed = blinkLed;

	property p_erase_blink;
		@(posedge clk) disable iff (!rst_n)
		(st_r.state == S_ERASE && ce && xferDone) |=> !st_r.erasing;
	endproperty
	a_erase_blink: assert property (p_erase_blink)
		else $error("Erase flag held after done");

	property p_no_config;
		@(posedge clk) disable iff (!rst_n)
		(diagCode == SCM_DIAG_NO_CONFIG) |-> !running;
	endproperty
	a_no_config: assert property (p_no_config)
		else $error("Running with no configuration");

	property p_reset_func;
		@(posedge clk) disable iff (!rst_n)
		resetFunc |-> !running && !req.start;
	endproperty
	a_reset_func: assert property (p_reset_func)
		else $error("Reset function with normal start");

	property p_section;
		@(posedge clk) disable iff (!rst_n)
		req.start |-> req.section == SCM_SEC_SAFETY;
	endproperty
	a_section: assert property (p_section)
		else $error("Non-safety section requested");

	property p_pull_diag;
		@(posedge clk) disable iff (!rst_n)
		(st_r.state == S_RUN && ce && !chipIn) |=> diagCode == SCM_DIAG_NO_CHIP;
	endproperty
	a_pull_diag: assert property (p_pull_diag)
		else $error("Chip pulled without diagnostic");

	property p_delete;
		@(posedge clk) disable iff (!rst_n)
		(st_r.state == S_RUN && ce && tool.deleteCmd && chipIn)
			|=> req.start && req.kind == XF_ERASE;
	endproperty
	a_delete: assert property (p_delete)
		else $error("Delete command not served");

	property p_check_first;
		@(posedge clk) disable iff (!rst_n)
		checkStart |-> st_r.state == S_CHECK && !req.start;
	endproperty
	a_check_first: assert property (p_check_first)
		else $error("Transfer before check");

	property p_mismatch;
		@(posedge clk) disable iff (!rst_n)
		(diagCode == SCM_DIAG_MISMATCH) |-> running;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("Mismatch without running");
endmodule : scm_manager

// ==== rtl/scm_pkg.sv ====
/*
 Shared constants and carriers for the configuration memory manager.
 Assumes one 100 MHz clock domain and a synchronous active-low reset.
*/
package scm_pkg;
	localparam logic [9:0] SCM_SW_RESET = 10'h384;
	localparam logic [9:0] SCM_SW_ERASE = 10'h385;
	localparam logic [9:0] SCM_SW_9XX_LO = 10'h384;
	localparam logic [9:0] SCM_SW_9XX_HI = 10'h3E7;
	localparam logic [9:0] SCM_DIAG_NONE = 10'h000;
	localparam logic [9:0] SCM_DIAG_NO_CHIP = 10'h200;
	localparam logic [9:0] SCM_DIAG_NO_CONFIG = 10'h201;
	localparam logic [9:0] SCM_DIAG_MISMATCH = 10'h202;
	localparam int SCM_CLK_MHZ = 100;
	localparam int SCM_BLINK_MS = 250;
	localparam int SCM_BLINK_CYC = SCM_BLINK_MS * 1000 * SCM_CLK_MHZ;
	localparam int SCM_SECTION_W = 2;
	localparam logic [1:0] SCM_SEC_SAFETY = 2'h1;

	typedef enum logic [1:0] {XF_NONE, XF_TO_CHIP, XF_TO_DEV, XF_ERASE} scm_xfer_e;

	typedef struct packed {
		logic devValid;
		logic chipPlugged;
		logic chipValid;
		logic copiesEqual;
	} scm_status_s;

	typedef struct packed {
		logic downloadDone;
		logic configChanged;
		logic deleteCmd;
	} scm_tool_s;

	typedef struct packed {
		logic start;
		scm_xfer_e kind;
		logic [SCM_SECTION_W-1:0] section;
	} scm_req_s;
endpackage : scm_pkg

// ==== verification/scm_store_model.sv ====
/*
 Storage engine stand-in: answers each transfer and check request.
 Assumes the manager's clock and at most one request outstanding.
*/
module scm_store_model
	import scm_pkg::*;
(
	// Clocking
	input wire logic clk,
	input wire logic rst_n,
	// Requests
	input wire scm_req_s req,
	input wire logic checkStart,
	input wire logic slow,
	// Answers
	output logic xferDone,
	output logic checkOk
);
	timeunit 1ns;
	timeprecision 1ps;
	int xCnt;
	int cCnt;
	// Slow mode keeps an erase long enough to see several blink phases
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			xferDone <= 1'h0;
			checkOk <= 1'h0;
			xCnt <= 0;
			cCnt <= 0;
		end
		else
		begin
			xferDone <= (xCnt == 1);
			checkOk <= (cCnt == 1);
			xCnt <= req.start ? (slow ? 20 : 2) : (xCnt > 0 ? xCnt - 1 : 0);
			cCnt <= checkStart ? 3 : (cCnt > 0 ? cCnt - 1 : 0);
		end
	end
endmodule : scm_store_model

// ==== verification/tb.sv ====
/*
 Self-checking bench for the configuration memory manager.
 Assumes the store model answers requests; ce is high but in one freeze test.
*/
module tb
	import scm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [3:0] st;
		scm_xfer_e k;
		logic run;
		logic [9:0] dg;
	} scm_row_s;
	scm_row_s rows [6] = '{
		'{4'h4, XF_NONE, 1'h0, SCM_DIAG_NO_CONFIG},
		'{4'h6, XF_TO_DEV, 1'h1, SCM_DIAG_NONE},
		'{4'hC, XF_TO_CHIP, 1'h1, SCM_DIAG_NONE},
		'{4'hF, XF_NONE, 1'h1, SCM_DIAG_NONE},
		'{4'hE, XF_NONE, 1'h1, SCM_DIAG_MISMATCH},
		'{4'h8, XF_NONE, 1'h0, SCM_DIAG_NO_CHIP}};
	logic clk, rst_n, ce, chipPresent, checkOk, xferDone, slow;
	logic checkStart, resetFunc, running, errLed;
	logic [9:0] switchSetting, diagCode;
	scm_status_s status;
	scm_tool_s tool;
	scm_req_s req;
	scm_xfer_e k;
	int mismatches = 0;
	int testsRun = 0;
	int nCheck = 0;
	scm_manager #(.BLINK_HALF(4)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.switchSetting(switchSetting), .chipPresent(chipPresent),
		.status(status), .tool(tool), .checkOk(checkOk),
		.xferDone(xferDone), .req(req), .checkStart(checkStart),
		.resetFunc(resetFunc), .running(running), .diagCode(diagCode),
		.errLed(errLed));
	scm_store_model u_store (.clk(clk), .rst_n(rst_n), .req(req),
		.checkStart(checkStart), .slow(slow), .xferDone(xferDone),
		.checkOk(checkOk));
	always #5 clk = ~clk;
	always @(posedge clk)
		if (checkStart === 1'h1)
			nCheck++;
	task automatic summarize();
		$display("checks %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		testsRun++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// A missing request that must come ends the run rather than hanging
	// Looks before each wait, as a request stands for one cycle only
	task automatic waitReq(input int n, input bit must, output scm_xfer_e q);
		q = XF_NONE;
		repeat (n)
		begin
			if (req.start === 1'h1)
			begin
				q = req.kind;
				return;
			end
			@(negedge clk);
		end
		if (must)
		begin
			mismatches++;
			summarize();
		end
	endtask : waitReq
	task automatic boot(input logic [3:0] st, input logic [9:0] sw);
		@(negedge clk);
		rst_n = 1'h0;
		status = st;
		chipPresent = st[2];
		switchSetting = sw;
		repeat (4) @(negedge clk);
		rst_n = 1'h1;
	endtask : boot
	task automatic pulse(input scm_tool_s t);
		@(negedge clk);
		tool = t;
		@(negedge clk);
		tool = '0;
	endtask : pulse
	task automatic blink();
		int n;
		logic last;
		n = 0;
		last = errLed;
		repeat (30)
		begin
			@(negedge clk);
			if (errLed !== last)
				n++;
			last = errLed;
		end
		chk(16'(n > 2), 16'h0001);
		chk(errLed, 1'h0);
	endtask : blink
	initial
	begin
		clk = 1'h0;
		rst_n = 1'h0;
		ce = 1'h1;
		switchSetting = 10'h000;
		chipPresent = 1'h0;
		status = '0;
		tool = '0;
		slow = 1'h0;
		repeat (12) @(negedge clk);
		chk(running, 1'h0);
		chk(diagCode, 10'h000);
		foreach (rows[i])
		begin
			boot(rows[i].st, 10'h000);
			waitReq(10, 1'b0, k);
			chk(k, rows[i].k);
			chk(running, rows[i].run);
			chk(diagCode, rows[i].dg);
		end
		boot(4'hF, 10'h000);
		repeat (8) @(negedge clk);
		pulse(3'h4);
		waitReq(6, 1'b1, k);
		chk(k, XF_TO_CHIP);
		chk(req.section, SCM_SEC_SAFETY);
		repeat (5) @(negedge clk);
		status.copiesEqual = 1'h0;
		pulse(3'h2);
		waitReq(12, 1'b1, k);
		chk(k, XF_TO_DEV);
		chk(16'(nCheck), 16'h0001);
		repeat (5) @(negedge clk);
		slow = 1'h1;
		pulse(3'h1);
		waitReq(6, 1'b1, k);
		chk(k, XF_ERASE);
		blink();
		chipPresent = 1'h0;
		status.chipPlugged = 1'h0;
		repeat (6) @(negedge clk);
		chk(diagCode, SCM_DIAG_NO_CHIP);
		chk(running, 1'h1);
		pulse(3'h4);
		waitReq(6, 1'b0, k);
		chk(k, XF_NONE);
		boot(4'hC, SCM_SW_ERASE);
		waitReq(10, 1'b1, k);
		chk(k, XF_ERASE);
		blink();
		boot(4'h6, SCM_SW_9XX_HI);
		waitReq(10, 1'b0, k);
		chk(k, XF_NONE);
		chk(diagCode, SCM_DIAG_NO_CONFIG);
		boot(4'hF, SCM_SW_RESET);
		ce = 1'h0;
		repeat (6) @(negedge clk);
		chk(resetFunc, 1'h0);
		ce = 1'h1;
		repeat (6) @(negedge clk);
		chk(resetFunc, 1'h1);
		summarize();
	end
endmodule : tb
